/* File: pkg/cpic_pkg.sv */
// Constants for the counter process image compare block.
// Assumes one 50 MHz clock and APB access with 32-bit data words.
//
// Summary of operation
// - Status bit shows the present state of the physical compare output.
// - Status bit shows the present state of the hardware digital input.
// - Running flag is 1 while a measuring operation is in progress.
// - Low limit flag sets on undershoot, holds until status clear rising edge.
// - High limit flag sets on overshoot, holds until status clear rising edge.
// - Measured value is refreshed each time the measuring interval elapses.
// - Compare one flag sets at interval end, holds until status clear edge.
// - Any parameter load during a running measurement stops the count.
// - Image parameters are volatile; reset restores default parameter set.
// - Output image is eight bytes: four value bytes, four control bytes.
// - Output functions are adopted only on a rising behaviour load bit.
// - Virtual function: direct, at least, at most, or equal pulse on reference two.
// - Physical function: direct, at least, at most, or equal pulse on reference one.
// - In direct function each output follows its direct bit while released.
// - Equality function emits a pulse whose length comes from image byte two.
// - Pulse length is an eight-bit count of milliseconds, 0 to 255.
// - Eight-bit hysteresis around both references suppresses rapid toggling.
// - Second output exists only as a status bit, never as a pin.
// - No new fault flag is set while fault acknowledge is held high.
// - Clear acknowledge mirrors status clear command of the last telegram.
// - An output is blocked while its release bit is 0.
package cpic_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] CPIC_OFS_IMG_LO = 8'h00; // Image bytes 0 to 3
    localparam logic [7:0] CPIC_OFS_IMG_HI = 8'h04; // Image bytes 4 to 7
    localparam logic [7:0] CPIC_OFS_COMMIT = 8'h08; // Write marks one telegram
    localparam logic [7:0] CPIC_OFS_STATUS = 8'h0c; // Process input status
    localparam logic [7:0] CPIC_OFS_MEAS = 8'h10;   // Measured value

    // ****************************************************************
    // Image low word fields (value bytes)
    // ****************************************************************
    localparam int CPIC_LO_PHYS_FN = 0;    // Two bits
    localparam int CPIC_LO_VIRT_FN = 2;    // Two bits
    localparam int CPIC_LO_HYST = 8;       // Byte 1
    localparam int CPIC_LO_PULSE = 16;     // Byte 2

    // ****************************************************************
    // Image high word fields (control bytes)
    // ****************************************************************
    localparam int CPIC_HI_LOAD_DIRECT = 0;
    localparam int CPIC_HI_LOAD_PREP = 1;
    localparam int CPIC_HI_LOAD_REF1 = 2;
    localparam int CPIC_HI_LOAD_REF2 = 3;
    localparam int CPIC_HI_BEH_LOAD = 4;
    localparam int CPIC_HI_SW_GATE = 8;
    localparam int CPIC_HI_STS_CLR = 10;
    localparam int CPIC_HI_PHYS_DIR = 11;
    localparam int CPIC_HI_PHYS_REL = 12;
    localparam int CPIC_HI_VIRT_DIR = 13;
    localparam int CPIC_HI_VIRT_REL = 14;
    localparam int CPIC_HI_FAULT_ACK = 15;

    // ****************************************************************
    // Status word fields
    // ****************************************************************
    localparam int CPIC_ST_PHYS = 0;
    localparam int CPIC_ST_HWIN = 1;
    localparam int CPIC_ST_RUN = 2;
    localparam int CPIC_ST_LOW = 3;
    localparam int CPIC_ST_HIGH = 4;
    localparam int CPIC_ST_CMP1 = 5;
    localparam int CPIC_ST_VIRT = 6;
    localparam int CPIC_ST_CLR_ACK = 7;
    localparam int CPIC_ST_FAULT = 8;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [31:0] CPIC_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] CPIC_RST_FN = 2'h0;
    localparam int CPIC_CLK_PERIOD_NS = 20;
    localparam int CPIC_PULSE_UNIT_NS = 1000000; // One millisecond
    localparam int CPIC_MS_CYCLES = CPIC_PULSE_UNIT_NS / CPIC_CLK_PERIOD_NS;

    // Output functions
    typedef enum logic [1:0] {
        CPIC_FN_DIRECT,
        CPIC_FN_AT_LEAST,
        CPIC_FN_AT_MOST,
        CPIC_FN_EQUAL
    } cpic_fn_t;

endpackage : cpic_pkg

/* File: hdl/cpic_top.sv */
// Process image face of a single channel counter with two compare outputs.
// Assumes the counting core runs on ref_clk and gives count, events, run level.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

module cpic_top
    import cpic_pkg::*;
#(
    parameter int MS_CYCLES = CPIC_MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hardware_digital_input,
    input wire logic [31:0] count_value,
    input wire logic measure_active,
    input wire logic low_limit_evt,
    input wire logic high_limit_evt,
    input wire logic interval_evt,
    input wire logic fault_evt,
    output logic physical_compare_output,
    output logic count_halt,
    output logic count_gate
);

    // ****************************************************************
    // Local types and constants
    // ****************************************************************
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    logic [31:0] img_lo_q;
    logic [31:0] img_hi_q;
    logic [31:0] cur_lo_q;
    logic [31:0] cur_hi_q;
    logic [31:0] prev_hi_q;
    logic tele_new_q;
    logic [31:0] edge_hi;
    logic param_edge;
    logic clr_edge;
    logic in_meta_q;
    logic in_sync_q;
    logic low_q;
    logic high_q;
    logic cmp1_q;
    logic fault_q;
    logic clr_ack_q;
    logic run_q;
    logic [31:0] meas_q;
    logic halt_q;
    logic gate_q;
    cpic_fn_t fn_q [2];
    logic [7:0] hyst_q;
    logic [7:0] pulse_len_q;
    logic [31:0] ref_q [2];
    logic out_q [2];
    logic [1:0] rel;
    logic [1:0] dir;
    logic apb_wr;
    logic [31:0] status_w;

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Zero wait states: ready rises in the first access cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    assign apb_wr = psel & penable & pready & pwrite;

    // Read data and error are prepared in the setup cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= CPIC_RST_WORD;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr <= 1'b0;
            prdata <= CPIC_RST_WORD;
            case (paddr)
                CPIC_OFS_IMG_LO: prdata <= img_lo_q;
                CPIC_OFS_IMG_HI: prdata <= img_hi_q;
                CPIC_OFS_COMMIT: prdata <= CPIC_RST_WORD;
                CPIC_OFS_STATUS: prdata <= status_w;
                CPIC_OFS_MEAS: prdata <= meas_q;
                default: pslverr <= 1'b1; // Unmapped address
            endcase
        end
    end

    // Staging image, byte lanes honoured; volatile, cleared by reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            img_lo_q <= CPIC_RST_WORD;
            img_hi_q <= CPIC_RST_WORD;
        end else if (apb_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b] && paddr == CPIC_OFS_IMG_LO) begin
                    img_lo_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
                if (pstrb[b] && paddr == CPIC_OFS_IMG_HI) begin
                    img_hi_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    // ****************************************************************
    // Telegram sampling
    // ****************************************************************

    // A commit write is one telegram; the previous one is kept for edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_lo_q <= CPIC_RST_WORD;
            cur_hi_q <= CPIC_RST_WORD;
            prev_hi_q <= CPIC_RST_WORD;
            tele_new_q <= 1'b0;
        end else begin
            tele_new_q <= apb_wr && paddr == CPIC_OFS_COMMIT;
            if (apb_wr && paddr == CPIC_OFS_COMMIT) begin
                cur_lo_q <= img_lo_q;
                cur_hi_q <= img_hi_q;
                prev_hi_q <= cur_hi_q;
            end
        end
    end

    // Edges exist only in the cycle after a telegram arrives
    assign edge_hi = tele_new_q ? (cur_hi_q & ~prev_hi_q) : CPIC_RST_WORD;
    assign clr_edge = edge_hi[CPIC_HI_STS_CLR];
    assign param_edge = |edge_hi[CPIC_HI_BEH_LOAD:CPIC_HI_LOAD_DIRECT];
    assign rel = {cur_hi_q[CPIC_HI_VIRT_REL], cur_hi_q[CPIC_HI_PHYS_REL]};
    assign dir = {cur_hi_q[CPIC_HI_VIRT_DIR], cur_hi_q[CPIC_HI_PHYS_DIR]};

    // ****************************************************************
    // Status flags
    // ****************************************************************

    // Pin crosses two flops before anything reads it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_q <= 1'b0;
            in_sync_q <= 1'b0;
        end else begin
            in_meta_q <= hardware_digital_input;
            in_sync_q <= in_meta_q;
        end
    end

    // Sticky flags; a set in the clearing cycle wins so no event is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= 1'b0;
            high_q <= 1'b0;
            cmp1_q <= 1'b0;
        end else begin
            low_q <= low_limit_evt | (low_q & ~clr_edge);
            high_q <= high_limit_evt | (high_q & ~clr_edge);
            cmp1_q <= interval_evt | (cmp1_q & ~clr_edge);
        end
    end

    // Acknowledge held high blocks new faults and clears old ones
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (cur_hi_q[CPIC_HI_FAULT_ACK]) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_q | fault_evt;
        end
    end

    // Acknowledge and running level mirror their sources
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_ack_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            clr_ack_q <= cur_hi_q[CPIC_HI_STS_CLR];
            run_q <= measure_active;
        end
    end

    // Measured value only moves at the end of an interval
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_q <= CPIC_RST_WORD;
        end else if (interval_evt) begin
            meas_q <= count_value;
        end
    end

    // Virtual output lives only here, never on a pin
    always_comb begin
        status_w = CPIC_RST_WORD;
        status_w[CPIC_ST_PHYS] = out_q[0];
        status_w[CPIC_ST_HWIN] = in_sync_q;
        status_w[CPIC_ST_RUN] = run_q;
        status_w[CPIC_ST_LOW] = low_q;
        status_w[CPIC_ST_HIGH] = high_q;
        status_w[CPIC_ST_CMP1] = cmp1_q;
        status_w[CPIC_ST_VIRT] = out_q[1];
        status_w[CPIC_ST_CLR_ACK] = clr_ack_q;
        status_w[CPIC_ST_FAULT] = fault_q;
    end

    // ****************************************************************
    // Count control
    // ****************************************************************

    // Halting on a live parameter change keeps counts from mixing sets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            halt_q <= param_edge & measure_active;
            gate_q <= cur_hi_q[CPIC_HI_SW_GATE] & ~(param_edge & measure_active);
        end
    end

    // ****************************************************************
    // Output behaviour and references
    // ****************************************************************

    // Functions, hysteresis and pulse length move only on the load edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_q[0] <= cpic_fn_t'(CPIC_RST_FN);
            fn_q[1] <= cpic_fn_t'(CPIC_RST_FN);
            hyst_q <= 8'h00;
            pulse_len_q <= 8'h00;
        end else if (edge_hi[CPIC_HI_BEH_LOAD]) begin
            fn_q[0] <= cpic_fn_t'(cur_lo_q[CPIC_LO_PHYS_FN +: 2]);
            fn_q[1] <= cpic_fn_t'(cur_lo_q[CPIC_LO_VIRT_FN +: 2]);
            hyst_q <= cur_lo_q[CPIC_LO_HYST +: 8];
            pulse_len_q <= cur_lo_q[CPIC_LO_PULSE +: 8];
        end
    end

    // References take the value bytes on their own load edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q[0] <= CPIC_RST_WORD;
            ref_q[1] <= CPIC_RST_WORD;
        end else begin
            if (edge_hi[CPIC_HI_LOAD_REF1]) begin
                ref_q[0] <= cur_lo_q;
            end
            if (edge_hi[CPIC_HI_LOAD_REF2]) begin
                ref_q[1] <= cur_lo_q;
            end
        end
    end

    // ****************************************************************
    // Compare channels: 0 physical, 1 virtual
    // ****************************************************************
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [32:0] cnt_w;
        logic [32:0] ref_w;
        logic [32:0] hys_w;
        logic on_q;
        logic eq_prev_q;
        logic act_q;
        logic [15:0] cyc_q;
        logic [7:0] ms_q;
        logic eq_start;
        logic cmp;

        assign cnt_w = {1'b0, count_value};
        assign ref_w = {1'b0, ref_q[c]};
        assign hys_w = {25'h0, hyst_q};
        assign eq_start = (count_value == ref_q[c]) & ~eq_prev_q;

        // On at the reference, off only past it by the hysteresis
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                on_q <= 1'b0;
            end else if (edge_hi[CPIC_HI_BEH_LOAD]) begin
                on_q <= 1'b0;
            end else begin
                case (fn_q[c])
                    CPIC_FN_AT_LEAST: begin
                        if (cnt_w >= ref_w) begin
                            on_q <= 1'b1;
                        end else if (cnt_w + hys_w < ref_w) begin
                            on_q <= 1'b0;
                        end
                    end
                    CPIC_FN_AT_MOST: begin
                        if (cnt_w <= ref_w) begin
                            on_q <= 1'b1;
                        end else if (cnt_w > ref_w + hys_w) begin
                            on_q <= 1'b0;
                        end
                    end
                    default: on_q <= 1'b0;
                endcase
            end
        end

        // Equality pulse; a zero length still gives one cycle
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                eq_prev_q <= 1'b0;
                act_q <= 1'b0;
                cyc_q <= 16'h0000;
                ms_q <= 8'h00;
            end else begin
                eq_prev_q <= count_value == ref_q[c];
                if (eq_start && fn_q[c] == CPIC_FN_EQUAL) begin
                    act_q <= pulse_len_q != 8'h00;
                    ms_q <= pulse_len_q;
                    cyc_q <= 16'h0000;
                end else if (act_q) begin
                    if (cyc_q == MS_LAST) begin
                        cyc_q <= 16'h0000;
                        ms_q <= ms_q - 8'h01;
                        act_q <= ms_q > 8'h01;
                    end else begin
                        cyc_q <= cyc_q + 16'h0001;
                    end
                end
            end
        end

        always_comb begin
            case (fn_q[c])
                CPIC_FN_DIRECT: cmp = dir[c];
                CPIC_FN_EQUAL: cmp = act_q | (eq_start & fn_q[c] == CPIC_FN_EQUAL);
                default: cmp = on_q;
            endcase
        end

        // Release gates every function
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                out_q[c] <= 1'b0;
            end else begin
                out_q[c] <= rel[c] & cmp;
            end
        end
    end

    assign physical_compare_output = out_q[0];
    assign count_halt = halt_q;
    assign count_gate = gate_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_low_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        low_q && !clr_edge |=> low_q) else $error("low limit flag lost");

    a_high_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        high_limit_evt |=> high_q) else $error("high limit flag not set");

    a_cmp1_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clr_edge && !interval_evt |=> !cmp1_q) else $error("compare flag not cleared");

    a_meas_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        interval_evt |=> meas_q == $past(count_value)) else $error("measured value stale");

    a_halt_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        param_edge && measure_active |=> count_halt && !count_gate)
        else $error("count not halted");

    a_fault_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cur_hi_q[CPIC_HI_FAULT_ACK] |=> !fault_q) else $error("fault set during ack");

    a_fn_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !edge_hi[CPIC_HI_BEH_LOAD] |=> $stable(fn_q[0]) && $stable(fn_q[1]))
        else $error("function changed without load edge");

    a_out_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rel[0] ##1 !rel[0] |-> !physical_compare_output) else $error("blocked output set");

    a_direct_fn: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fn_q[1] == CPIC_FN_DIRECT |=> out_q[1] == $past(rel[1] & dir[1]))
        else $error("direct function wrong");

    a_clr_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tele_new_q |=> clr_ack_q == $past(cur_hi_q[CPIC_HI_STS_CLR]))
        else $error("clear ack wrong");

    a_run_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        measure_active |=> status_w[CPIC_ST_RUN]) else $error("running flag low");

endmodule : cpic_top

/* File: dv/cpic_plc.sv */
// PLC side model: sends process output telegrams to the block over APB.
// Assumes one shared clock and a bench that calls its tasks just after an edge.
`timescale 1ns/1ps

module cpic_plc
    import cpic_pkg::*;
(
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ********************
    // Bus master
    // ********************
    int tmo = 0;
    logic [31:0] q;
    logic e;

    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end

    // One transfer; waits for pready under a bound, takes q and e at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) tmo++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Released data must not look valid
    endtask : xfer

    // Eight byte image, then the commit marker
    task automatic tel(input logic [31:0] lo, input logic [31:0] hi);
        xfer(1'b1, CPIC_OFS_IMG_LO, lo);
        xfer(1'b1, CPIC_OFS_IMG_HI, hi);
        xfer(1'b1, CPIC_OFS_COMMIT, 32'h0000_0000);
        repeat (4) @(posedge ref_clk); // Update lands by the third edge
    endtask : tel

endmodule : cpic_plc

/* File: dv/counter_process_image_compare_test.sv */
// Self-checking bench for the process image compare block.
// Assumes the PLC model drives APB and the bench drives the counting core side.
`timescale 1ns/1ps

module counter_process_image_compare_test
    import cpic_pkg::*;
;
    // ********************
    // Harness
    // ********************
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, hwin, run, pin, halt, gate;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cnt, s;
    logic [3:0] pstrb, evt;
    logic halt_seen = 1'b0;
    int err_count = 0;
    int tests_run = 0;

    cpic_top #(.MS_CYCLES(10)) cpic_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hardware_digital_input(hwin),
        .count_value(cnt), .measure_active(run), .low_limit_evt(evt[0]),
        .high_limit_evt(evt[1]), .interval_evt(evt[2]), .fault_evt(evt[3]),
        .physical_compare_output(pin), .count_halt(halt), .count_gate(gate));
    cpic_plc cpic_plc_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // Halt is a one-cycle pulse, so latch it rather than poll it
    always @(posedge ref_clk) if (halt === 1'b1) halt_seen <= 1'b1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a);
        cpic_plc_i.xfer(1'b0, a, 32'h0000_0000);
        s = cpic_plc_i.q;
    endtask : rd

    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        evt <= m;
        @(posedge ref_clk);
        evt <= 4'h0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse

    task automatic cv(input logic [31:0] v, input logic exp);
        @(posedge ref_clk);
        cnt <= v;
        repeat (4) @(posedge ref_clk);
        chk(pin, exp);
    endtask : cv

    // ********************
    // Scenarios
    // ********************
    task automatic t_direct;
        rd(CPIC_OFS_STATUS);
        chk(s, 32'h0000_0000);
        cpic_plc_i.tel(0, (1 << CPIC_HI_BEH_LOAD) | (1 << CPIC_HI_PHYS_DIR));
        chk(pin, 1'b0);
        cpic_plc_i.tel(0, 32'h0000_7800);
        chk(pin, 1'b1);
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_PHYS], 1'b1);
        chk(s[CPIC_ST_VIRT], 1'b1);
        $display("test direct done");
    endtask : t_direct

    task automatic t_flags;
        @(posedge ref_clk);
        hwin <= 1'b1;
        run <= 1'b1;
        cnt <= 32'h0000_1234;
        pulse(4'h7);
        rd(CPIC_OFS_STATUS);
        chk(s[5:1], 5'h1f);
        rd(CPIC_OFS_MEAS);
        chk(s, 32'h0000_1234);
        cpic_plc_i.tel(0, 1 << CPIC_HI_STS_CLR);
        rd(CPIC_OFS_STATUS);
        chk(s[7:3], 5'h10);
        cpic_plc_i.tel(0, 0);
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_CLR_ACK], 1'b0);
        $display("test flags done");
    endtask : t_flags

    task automatic t_cmp;
        cv(99, 1'b0);
        cpic_plc_i.tel(100, (1 << CPIC_HI_LOAD_REF1) | (1 << CPIC_HI_SW_GATE));
        chk(halt_seen, 1'b1);
        chk(gate, 1'b1);
        cpic_plc_i.tel(32'h0000_0501, 32'h0000_1010);
        chk(pin, 1'b0);
        cv(100, 1'b1);
        cv(96, 1'b1);
        cv(94, 1'b0);
        cpic_plc_i.tel(200, (1 << CPIC_HI_LOAD_REF2) | (1 << CPIC_HI_PHYS_REL));
        cpic_plc_i.tel(32'h0000_0008, (1 << CPIC_HI_BEH_LOAD) | (1 << CPIC_HI_VIRT_REL));
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_VIRT], 1'b1);
        cv(201, 1'b0);
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_VIRT], 1'b0);
        $display("test compare done");
    endtask : t_cmp

    // Equality pulse of three ms at ten cycles per ms: high near 24, low by 34
    task automatic t_equal;
        cpic_plc_i.tel(0, 0);
        cpic_plc_i.tel(32'h0003_0003, (1 << CPIC_HI_BEH_LOAD) | (1 << CPIC_HI_PHYS_REL));
        cv(100, 1'b1);
        repeat (20) @(posedge ref_clk);
        chk(pin, 1'b1);
        repeat (10) @(posedge ref_clk);
        chk(pin, 1'b0);
        $display("test equal done");
    endtask : t_equal

    task automatic t_fault;
        // Acknowledge raised with no fault pending, then dropped
        cpic_plc_i.tel(0, 1 << CPIC_HI_FAULT_ACK);
        pulse(4'h8);
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_FAULT], 1'b0);
        cpic_plc_i.tel(0, 0);
        pulse(4'h8);
        rd(CPIC_OFS_STATUS);
        chk(s[CPIC_ST_FAULT], 1'b1);
        rd(8'h20);
        chk(cpic_plc_i.e, 1'b1);
        $display("test fault done");
    endtask : t_fault

    task automatic finish_test;
        err_count += cpic_plc_i.tmo;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Clock and bounded watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        for (int i = 0; i < 20000 && cpic_plc_i.tmo == 0; i++) @(posedge ref_clk);
        err_count++;
        finish_test;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        hwin = 1'b0;
        run = 1'b0;
        cnt = 32'h0000_0000;
        evt = 4'h0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_direct;
        t_flags;
        t_cmp;
        t_equal;
        t_fault;
        finish_test;
    end

endmodule : counter_process_image_compare_test
